// ==== rtl/ee_serial_eeprom.sv ====
// Summary of operation
// - data change while clock high is start/stop
// - start is data falling with clock high
// - stop is data rising with clock high
// - sample on rise, shift out after fall
// - data line is open drain only
// - eight bit words, ack in ninth cycle
// - standby at power up and after stop; a write stop waits for programming to end
// - nine clocks then start stop recovers idle
// - device word: 1010, three address bits, r/w
// - r/w one reads, zero writes
// - mismatch gives no ack and standby
// - eleven bit address, 128 pages of 16
// - byte write: stop launches programming
// - programming cycle ignores the bus
// - page write takes up to sixteen bytes
// - page write wraps lower four bits only
// - ack polling answers only when idle
// - counter is last address plus one
// - current read sends byte at counter
// - master ack continues sequential read
// - write protect inhibits all programming
`timescale 1ns/1ps
`default_nettype none
`include "ee_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module ee_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_r;
	logic [AW:0] rdPtr_r;
	logic [AW:0] level;
	assign level = wrPtr_r - rdPtr_r;
	assign inReady = (level != DEPTH[AW:0]);
	assign outValid = (level != '0);
	assign outData = mem[rdPtr_r[AW-1:0]];
	always_ff @(posedge clk) begin
		if (inValid && inReady) begin
			mem[wrPtr_r[AW-1:0]] <= inData;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
		end else begin
			if (inValid && inReady) begin
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (outValid && outReady) begin
				rdPtr_r <= rdPtr_r + 1'b1;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module ee_serial_eeprom #(
	parameter int PROG_CYCLES = `EE_PROG_CYCLES,
	parameter int FIFO_DEPTH = `EE_FIFO_DEPTH
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// two-wire bus pins
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// write protect pin
	input wire logic writeProtect,
	// status
	output logic progBusy,
	output logic standby
);
	localparam int AW = `EE_ADDR_W;
	localparam int PB = `EE_PAGE_BITS;

	logic [7:0] mem [`EE_MEM_WORDS];

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0] sclSync_r;
	logic [1:0] sdaSync_r;
	logic [1:0] wpSync_r;
	logic sclPrev_r;
	logic sdaPrev_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sclSync_r <= 2'h3;
			sdaSync_r <= 2'h3;
			wpSync_r <= 2'h0;
			sclPrev_r <= 1'b1;
			sdaPrev_r <= 1'b1;
		end else begin
			sclSync_r <= {sclSync_r[0], sclIn};
			sdaSync_r <= {sdaSync_r[0], sdaIn};
			wpSync_r <= {wpSync_r[0], writeProtect};
			sclPrev_r <= sclSync_r[1];
			sdaPrev_r <= sdaSync_r[1];
		end
	end
	logic scl;
	logic sda;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	assign scl = sclSync_r[1];
	assign sda = sdaSync_r[1];
	assign sclRise = scl && !sclPrev_r;
	assign sclFall = !scl && sclPrev_r;
	// data edges while clock stays high are conditions, never data
	assign startCond = scl && sclPrev_r && sdaPrev_r && !sda;
	assign stopCond = scl && sclPrev_r && !sdaPrev_r && sda;

	////////////////////////////////////////////////////////////////////////////
	// byte framing
	ee_pkg::ee_state_e state_r;
	logic [3:0] bitCnt_r;
	logic [7:0] shift_r;
	logic [7:0] txByte_r;
	logic ackDrive_r;
	logic dataDrive_r;
	logic [AW-1:0] addr_r;
	logic [AW-1:0] pageBase_r;
	logic [PB-1:0] pageOffs_r;
	logic pendWrite_r;
	logic [PB:0] byteCount_r;
	logic [31:0] progCnt_r;
	logic [PB:0] drainCnt_r;
	logic [7:0] rxByte;
	logic byteDone;
	logic ninthRise;
	logic devMatch;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoOutReady;
	ee_pkg::ee_wbyte_s fifoIn;
	ee_pkg::ee_wbyte_s fifoOut;
	logic fifoPush;
	logic progDone;

	assign rxByte = {shift_r[6:0], sda};
	// eighth sampled bit completes a word, msb first
	assign byteDone = sclRise && (bitCnt_r == 4'h7);
	assign ninthRise = sclRise && (bitCnt_r == 4'h8);
	assign devMatch = (rxByte[7:4] == `EE_DEV_CODE);
	assign fifoPush = (state_r == ee_pkg::ST_WRDATA) && byteDone;
	assign fifoIn.offs = pageOffs_r;
	assign fifoIn.data = rxByte;

	// no bit clock stall exists: a byte offered to a full buffer is dropped, but
	// the drain takes one entry every cycle, so the buffer never fills
	ee_fifo #(
		.WIDTH($bits(ee_pkg::ee_wbyte_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(core_clk),
		.rst(rst),
		.inValid(fifoPush),
		.inReady(fifoInReady),
		.inData(fifoIn),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData(fifoOut)
	);

	////////////////////////////////////////////////////////////////////////////
	// page buffer: only received bytes carry a valid mark
	logic [7:0] pageBuf_r [1 << PB];
	logic [(1 << PB)-1:0] pageValid_r;
	assign fifoOutReady = 1'b1;
	always_ff @(posedge core_clk) begin
		if (fifoOutValid) begin
			pageBuf_r[fifoOut.offs] <= fifoOut.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// protocol state machine
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= ee_pkg::ST_IDLE;
			bitCnt_r <= 4'h0;
			shift_r <= 8'h00;
			ackDrive_r <= 1'b0;
			dataDrive_r <= 1'b0;
			txByte_r <= 8'h00;
			addr_r <= '0;
			pageBase_r <= '0;
			pageOffs_r <= '0;
			pendWrite_r <= 1'b0;
			byteCount_r <= '0;
		end else if (progBusy) begin
			// inputs disabled while programming, no answer to polling
			state_r <= ee_pkg::ST_IDLE;
			bitCnt_r <= 4'h0;
			ackDrive_r <= 1'b0;
			dataDrive_r <= 1'b0;
			pendWrite_r <= 1'b0;
			byteCount_r <= '0;
		end else if (startCond) begin
			// a start always resynchronises, which gives bus recovery
			state_r <= ee_pkg::ST_DEVADDR;
			bitCnt_r <= 4'h0;
			ackDrive_r <= 1'b0;
			dataDrive_r <= 1'b0;
			// only a stop launches programming; a restart abandons the write
			pendWrite_r <= 1'b0;
			byteCount_r <= '0;
		end else if (stopCond) begin
			state_r <= ee_pkg::ST_IDLE;
			bitCnt_r <= 4'h0;
			ackDrive_r <= 1'b0;
			dataDrive_r <= 1'b0;
			pendWrite_r <= 1'b0;
			byteCount_r <= '0;
		end else if (state_r != ee_pkg::ST_IDLE && state_r != ee_pkg::ST_IGNORE) begin
			if (sclRise) begin
				bitCnt_r <= (bitCnt_r == 4'h8) ? 4'h0 : bitCnt_r + 4'h1;
				if (bitCnt_r < 4'h8) begin
					shift_r <= rxByte;
				end
			end
			if (byteDone) begin
				case (state_r)
					ee_pkg::ST_DEVADDR: begin
						if (!devMatch) begin
							state_r <= ee_pkg::ST_IGNORE;
						end else begin
							ackDrive_r <= 1'b0;
							addr_r[AW-1:8] <= rxByte[3:1];
						end
					end
					ee_pkg::ST_WORDADDR: begin
						addr_r[7:0] <= rxByte;
						pageBase_r <= {addr_r[AW-1:8], rxByte};
						pageOffs_r <= rxByte[PB-1:0];
					end
					ee_pkg::ST_WRDATA: begin
						pendWrite_r <= !wpSync_r[1];
						pageOffs_r <= pageOffs_r + 1'b1;
						addr_r <= {addr_r[AW-1:PB], pageOffs_r + 1'b1};
						if (byteCount_r != 5'h10) begin
							byteCount_r <= byteCount_r + 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
			if (sclFall) begin
				// drive after falling edge only: line moves while clock low
				if (bitCnt_r == 4'h8) begin
					case (state_r)
						ee_pkg::ST_DEVADDR: begin
							ackDrive_r <= 1'b1;
							dataDrive_r <= 1'b0;
						end
						ee_pkg::ST_WORDADDR, ee_pkg::ST_WRDATA: begin
							ackDrive_r <= 1'b1;
						end
						ee_pkg::ST_RDDATA: begin
							dataDrive_r <= 1'b0; // master owns ninth bit
						end
						default: begin
						end
					endcase
				end else if (bitCnt_r == 4'h0) begin
					ackDrive_r <= 1'b0;
					if (state_r == ee_pkg::ST_RDDATA) begin
						dataDrive_r <= 1'b1;
					end
				end else if (state_r == ee_pkg::ST_RDDATA) begin
					txByte_r <= {txByte_r[6:0], 1'b1};
				end
			end
			if (ninthRise) begin
				case (state_r)
					ee_pkg::ST_DEVADDR: begin
						if (shift_r[0]) begin
							state_r <= ee_pkg::ST_RDDATA;
							txByte_r <= mem[addr_r];
							addr_r <= addr_r + 1'b1;
							dataDrive_r <= 1'b0;
						end else begin
							state_r <= ee_pkg::ST_WORDADDR;
						end
					end
					ee_pkg::ST_WORDADDR: begin
						state_r <= ee_pkg::ST_WRDATA;
					end
					ee_pkg::ST_RDDATA: begin
						if (!sda) begin
							txByte_r <= mem[addr_r];
							addr_r <= addr_r + 1'b1;
						end else begin
							state_r <= ee_pkg::ST_IGNORE;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// open drain: output data tied low, enable selects pull-down
	assign sdaOut = 1'b0;
	assign sdaOe = ackDrive_r || (dataDrive_r && !txByte_r[7]);

	////////////////////////////////////////////////////////////////////////////
	// received-byte marks for the page buffer
	logic newSeq;
	// a fresh word address opens a new page image, so bytes left over from a
	// protected or abandoned write are never programmed by a later stop
	assign newSeq = byteDone && (state_r == ee_pkg::ST_WORDADDR);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pageValid_r <= '0;
		end else if (progDone || newSeq) begin
			pageValid_r <= '0;
		end else if (fifoOutValid) begin
			pageValid_r[fifoOut.offs] <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// internally timed programming cycle
	logic launch;
	assign launch = stopCond && pendWrite_r && !progBusy && !wpSync_r[1];
	assign progDone = progBusy && (progCnt_r == 32'h0) && !fifoOutValid;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			progBusy <= 1'b0;
			progCnt_r <= 32'h0;
		end else if (launch) begin
			progBusy <= 1'b1;
			progCnt_r <= 32'(PROG_CYCLES - 1);
		end else if (progBusy) begin
			if (progCnt_r != 32'h0) begin
				progCnt_r <= progCnt_r - 32'h1;
			end else if (!fifoOutValid) begin
				progBusy <= 1'b0;
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (progDone) begin
			for (int i = 0; i < (1 << PB); i++) begin
				if (pageValid_r[i]) begin
					mem[{pageBase_r[AW-1:PB], PB'(i)}] <= pageBuf_r[i];
				end
			end
		end
	end

	// an unaddressed device waits quietly for the next start
	assign standby = ((state_r == ee_pkg::ST_IDLE) || (state_r == ee_pkg::ST_IGNORE)) && !progBusy;
endmodule
`default_nettype wire

// ==== rtl/ee_defs.svh ====
`ifndef EE_DEFS_SVH
`define EE_DEFS_SVH
`define EE_DEV_CODE 4'ha
`define EE_ADDR_W 11
`define EE_PAGE_BITS 4
`define EE_MEM_WORDS 2048
`define EE_FIFO_DEPTH 4
`define EE_PROG_TIME_US 3000
`define EE_CLK_MHZ 20
`define EE_PROG_CYCLES (`EE_PROG_TIME_US * `EE_CLK_MHZ)
`endif

// ==== rtl/ee_pkg.sv ====
package ee_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEVADDR = 3'b001,
		ST_WORDADDR = 3'b010,
		ST_WRDATA = 3'b011,
		ST_RDDATA = 3'b100,
		ST_RDACK = 3'b101,
		ST_IGNORE = 3'b110
	} ee_state_e;
	typedef struct packed {
		logic [3:0] offs;
		logic [7:0] data;
	} ee_wbyte_s;
endpackage

// ==== testbench/ee_serial_eeprom_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module ee_serial_eeprom_checker #(
	parameter int PROG_CYCLES = 50
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// bus pins
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	// control and status
	input wire logic writeProtect,
	input wire logic progBusy,
	input wire logic standby
);
	logic [15:0] busyCnt_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// length of the running programming cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			busyCnt_r <= 16'h0;
		else
			busyCnt_r <= progBusy ? busyCnt_r + 16'h1 : 16'h0;
	end
	property p_openDrain; sdaOut == 1'b0; endproperty
	a_openDrain: assert property (p_openDrain) else $error("data line driven high");
	property p_oeOnLow; $changed(sdaOe) |-> !$past(sclIn); endproperty
	a_oeOnLow: assert property (p_oeOnLow) else $error("data changed with clock high");
	property p_ackHold; $rose(sdaOe) |=> sdaOe [*3]; endproperty
	a_ackHold: assert property (p_ackHold) else $error("low bit too short");
	property p_busyNotIdle; progBusy |-> !standby; endproperty
	a_busyNotIdle: assert property (p_busyNotIdle) else $error("standby while busy");
	property p_busyQuiet; progBusy |-> !sdaOe; endproperty
	a_busyQuiet: assert property (p_busyQuiet) else $error("answer while busy");
	property p_idleQuiet; standby |-> !sdaOe; endproperty
	a_idleQuiet: assert property (p_idleQuiet) else $error("answer in standby");
	property p_wpBlocks; $rose(progBusy) |-> !writeProtect; endproperty
	a_wpBlocks: assert property (p_wpBlocks) else $error("programmed while protected");
	property p_busyMax; progBusy |-> busyCnt_r < PROG_CYCLES + 32; endproperty
	a_busyMax: assert property (p_busyMax) else $error("programming too long");
	property p_busyMin; $fell(progBusy) |-> busyCnt_r >= PROG_CYCLES; endproperty
	a_busyMin: assert property (p_busyMin) else $error("programming too short");
	c_prog: cover property ($rose(progBusy));
	c_ack: cover property ($rose(sdaOe));
	c_wake: cover property ($fell(standby));
endmodule
////////////////////////////////
bind ee_serial_eeprom ee_serial_eeprom_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (.core_clk(core_clk),
	.rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.writeProtect(writeProtect), .progBusy(progBusy), .standby(standby));
`default_nettype wire

// ==== testbench/ee_bus_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module ee_bus_ctrl (
	// clock
	input wire logic clk,
	// bus
	output logic scl,
	output logic sdaPull,
	input wire logic sdaLine
);
	initial begin
		scl = 1'b1;
		sdaPull = 1'b0;
	end
	task automatic t(input int n);
		repeat (n) @(posedge clk);
	endtask
	////////////////////////////////
	// one 400 ns bit; data only moves while the clock is low
	task automatic bitx(input logic b, output logic s);
		sdaPull <= !b;
		t(2);
		scl <= 1'b1;
		t(3);
		s = sdaLine;
		t(1);
		scl <= 1'b0;
		t(2);
	endtask
	// long low first: the device may still be releasing its low bit
	task automatic start();
		sdaPull <= 1'b0;
		t(4);
		scl <= 1'b1;
		t(4);
		sdaPull <= 1'b1;
		t(4);
		scl <= 1'b0;
		t(2);
	endtask
	task automatic stop();
		sdaPull <= 1'b1;
		t(4);
		scl <= 1'b1;
		t(4);
		sdaPull <= 1'b0;
		t(4);
	endtask
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitx(b[i], s);
		bitx(1'b1, s);
		ack = !s;
	endtask
	task automatic getByte(input logic more, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, s);
			b[i] = s;
		end
		bitx(!more, s);
	endtask
	task automatic recover();
		logic s;
		repeat (9) bitx(1'b1, s);
		start();
		stop();
	endtask
endmodule
`default_nettype wire

// ==== testbench/test_ee_serial_eeprom.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module test_ee_serial_eeprom;
	localparam int PROG = 200;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic writeProtect = 1'b0;
	logic sdaOut, sdaOe, progBusy, standby, scl, mstPull, ack;
	logic [7:0] rd;
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;
	// pull-up: the line is low only while someone pulls it
	wire sdaLine = !((sdaOe && !sdaOut) || mstPull);
	always #25 core_clk = ~core_clk;
	ee_serial_eeprom #(.PROG_CYCLES(PROG)) uut (.core_clk(core_clk), .rst(rst),
		.sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .writeProtect(writeProtect),
		.progBusy(progBusy), .standby(standby));
	ee_bus_ctrl mst (.clk(core_clk), .scl(scl), .sdaPull(mstPull), .sdaLine(sdaLine));
	////////////////////////////////
	task automatic addr(input logic [10:0] a);
		mst.start();
		mst.sendByte({4'ha, a[10:8], 1'b0}, ack);
		`CHK("devAck", 1'b1, ack);
		mst.sendByte(a[7:0], ack);
		`CHK("wordAck", 1'b1, ack);
	endtask
	task automatic readAt(input logic [10:0] a, input logic [7:0] exp);
		addr(a);
		mst.start();
		mst.sendByte({4'ha, a[10:8], 1'b1}, ack);
		mst.getByte(1'b0, rd);
		mst.stop();
		`CHK("randRead", exp, rd);
	endtask
	task automatic waitIdle();
		ack = 1'b0;
		for (int i = 0; i < 20 && !ack; i++) begin
			mst.start();
			mst.sendByte(8'ha0, ack);
			mst.stop();
		end
		mst.t(4);
		`CHK("idle", 1'b1, standby);
	endtask
	task automatic s_byteWrite();
		addr(11'h000);
		mst.sendByte(8'h5a, ack);
		`CHK("dataAck", 1'b1, ack);
		mst.stop();
		mst.t(4);
		`CHK("busy", 1'b1, progBusy);
		mst.start();
		mst.sendByte(8'ha0, ack);
		mst.stop();
		`CHK("pollNack", 1'b0, ack);
		waitIdle();
		$display("byte write done");
	endtask
	task automatic s_pageWrite();
		addr(11'h7fe);
		for (int i = 0; i < 3; i++) begin
			mst.sendByte({2{4'(i + 1)}}, ack);
			`CHK("pageAck", 1'b1, ack);
		end
		mst.stop();
		waitIdle();
		readAt(11'h7f0, 8'h33);
		$display("page write done");
	endtask
	task automatic s_reads();
		addr(11'h7fe);
		mst.start();
		mst.sendByte(8'haf, ack);
		`CHK("rdAck", 1'b1, ack);
		mst.getByte(1'b1, rd);
		`CHK("seq0", 8'h11, rd);
		mst.getByte(1'b0, rd);
		`CHK("seq1", 8'h22, rd);
		mst.stop();
		mst.start();
		mst.sendByte(8'ha1, ack);
		mst.getByte(1'b0, rd);
		mst.stop();
		`CHK("curRead", 8'h5a, rd);
		$display("reads done");
	endtask
	task automatic s_protect();
		writeProtect <= 1'b1;
		addr(11'h000);
		mst.sendByte(8'ha5, ack);
		`CHK("wpAck", 1'b1, ack);
		mst.stop();
		mst.t(8);
		`CHK("wpBusy", 1'b0, progBusy);
		writeProtect <= 1'b0;
		readAt(11'h000, 8'h5a);
		// a later write in the same page must not carry the refused byte along
		addr(11'h001);
		mst.sendByte(8'h3c, ack);
		`CHK("partAck", 1'b1, ack);
		mst.stop();
		waitIdle();
		readAt(11'h000, 8'h5a);
		readAt(11'h001, 8'h3c);
		$display("protect done");
	endtask
	task automatic s_badCode();
		mst.start();
		mst.sendByte(8'h5e, ack);
		`CHK("badNack", 1'b0, ack);
		`CHK("badIdle", 1'b1, standby);
		mst.recover();
		mst.t(4);
		`CHK("recovered", 1'b1, standby);
		readAt(11'h7ff, 8'h22);
		$display("bad code done");
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// a hung handshake ends the run here
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			err_count++;
			wrap_up();
		end
	end
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		mst.t(4);
		`CHK("resetIdle", 1'b1, standby);
		s_byteWrite();
		s_pageWrite();
		s_reads();
		s_protect();
		s_badCode();
		wrap_up();
	end
endmodule
`default_nettype wire
